// ---- logic/cwg_pkg.sv ----
// constants shared by the complementary waveform generator
package cwg_pkg;
    // register offsets
    localparam logic [3:0] ADDR_CONTROL_0 = 4'h0;
    localparam logic [3:0] ADDR_POLARITY = 4'h1;
    localparam logic [3:0] ADDR_CLOCK_CONTROL = 4'h2;
    localparam logic [3:0] ADDR_INPUT_SELECT = 4'h3;
    localparam logic [3:0] ADDR_RISING_DB = 4'h4;
    localparam logic [3:0] ADDR_FALLING_DB = 4'h5;
    localparam logic [3:0] ADDR_STEERING = 4'h6;
    localparam logic [3:0] ADDR_STATUS = 4'h7;
    // generator_control_0 fields
    localparam int EN_BIT = 7;
    localparam int LD_BIT = 6;
    localparam int MODE_LSB = 0;
    localparam int MODE_W = 3;
    // generator_clock_control field
    localparam int CLK_SEL_BIT = 0;
    // status fields
    localparam int STAT_SHUTDOWN_BIT = 7;
    localparam int STAT_NEXT_B_BIT = 6;
    localparam int STAT_FB_HOLD_BIT = 5;
    localparam int STAT_REVERSE_BIT = 4;
    // mode codes
    localparam logic [2:0] MODE_STEER_ASYNC = 3'h0;
    localparam logic [2:0] MODE_STEER_SYNC = 3'h1;
    localparam logic [2:0] MODE_FB_FORWARD = 3'h2;
    localparam logic [2:0] MODE_FB_REVERSE = 3'h3;
    localparam logic [2:0] MODE_HALF_BRIDGE = 3'h4;
    localparam logic [2:0] MODE_PUSH_PULL = 3'h5;
    // reset values
    localparam logic [2:0] RESET_MODE = 3'h0;
    localparam logic [3:0] RESET_POLARITY = 4'hF;
    localparam logic [5:0] RESET_DB = 6'h00;
    localparam logic [3:0] RESET_STEER = 4'h0;
    localparam logic [3:0] RESET_SOURCE = 4'h0;
    // widths
    localparam int DB_W = 6;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 4;
    // fast oscillator rate in MHz
    localparam int FAST_OSC_MHZ = 16;
endpackage

// ---- logic/cwg_top.sv ----
// complementary waveform generator core with register port
`timescale 1ns/1ns
`default_nettype none
module cwg_top #(
    parameter int SRC_COUNT = 16
) (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic reset_n_in,
    // register port
    input wire logic [cwg_pkg::ADDR_W-1:0] reg_addr_in,
    input wire logic [cwg_pkg::DATA_W-1:0] reg_wdata_in,
    input wire logic reg_write_in,
    input wire logic reg_read_in,
    output logic [cwg_pkg::DATA_W-1:0] reg_rdata_out,
    // waveform sources and events
    input wire logic [SRC_COUNT-1:0] input_sources_in,
    input wire logic fast_osc_tick_in,
    input wire logic shutdown_in,
    // outputs to power switches
    output logic wave_out_a,
    output logic wave_out_b,
    output logic wave_out_c,
    output logic wave_out_d
);

    // polarity applied last so inactive stays meaningful per output
    function automatic logic apply_pol(input logic raw, input logic pol);
        apply_pol = pol ? raw : ~raw;
    endfunction

    // one step of a dead-band counter
    function automatic logic [cwg_pkg::DB_W-1:0] db_step(
        input logic [cwg_pkg::DB_W-1:0] cnt,
        input logic [cwg_pkg::DB_W-1:0] limit,
        input logic tick
    );
        db_step = (tick && cnt != limit) ? cnt + 6'h01 : cnt;
    endfunction

    logic enable;
    logic load_request;
    logic [2:0] mode;
    logic [3:0] output_polarity_bits;
    logic clk_sel;
    logic [3:0] source_sel;
    logic [cwg_pkg::DB_W-1:0] rise_buf;
    logic [cwg_pkg::DB_W-1:0] fall_buf;
    logic [cwg_pkg::DB_W-1:0] rise_act;
    logic [cwg_pkg::DB_W-1:0] fall_act;
    logic [3:0] steer_sel;
    logic [3:0] steer_act;
    logic data_q;
    logic [cwg_pkg::DB_W-1:0] rise_cnt;
    logic [cwg_pkg::DB_W-1:0] fall_cnt;
    logic [cwg_pkg::DB_W-1:0] fb_cnt;
    logic fb_hold;
    logic reverse;
    logic next_is_b;
    logic route_b;

    logic input_waveform;
    logic data_rise;
    logic data_fall;
    logic gen_tick;
    logic wr_ctrl;
    logic seq_clear;
    logic is_full_bridge;
    logic next_reverse;
    logic [3:0] next_steer;
    logic next_route_b;
    logic [3:0] raw;
    logic fb_open;

    assign input_waveform = input_sources_in[source_sel];
    assign data_rise = input_waveform & ~data_q;
    assign data_fall = ~input_waveform & data_q;
    // fast tick is a synchronous one-cycle pulse; the 10 MHz core cannot host 16 MHz
    assign gen_tick = clk_sel ? fast_osc_tick_in : 1'b1;
    assign wr_ctrl = reg_write_in && reg_addr_in == cwg_pkg::ADDR_CONTROL_0;
    assign seq_clear = ~enable | shutdown_in;
    assign is_full_bridge = mode[2:1] == cwg_pkg::MODE_FB_FORWARD[2:1];
    // modulated pin opens once the count reaches its limit, like half-bridge
    assign fb_open = !fb_hold || fb_cnt == (reverse ? rise_act : fall_act);

    // control register
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            enable <= 1'b0;
            mode <= cwg_pkg::RESET_MODE;
        end else if (wr_ctrl) begin
            enable <= reg_wdata_in[cwg_pkg::EN_BIT];
            // every mode bit may change while running
            mode <= reg_wdata_in[cwg_pkg::MODE_LSB +: cwg_pkg::MODE_W];
        end
    end

    // load request: software set wins over hardware clear
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            load_request <= 1'b0;
        end else if (wr_ctrl && reg_wdata_in[cwg_pkg::LD_BIT]) begin
            load_request <= 1'b1;
        end else if (!enable || data_fall) begin
            load_request <= 1'b0;
        end
    end

    // plain configuration registers
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            output_polarity_bits <= cwg_pkg::RESET_POLARITY;
            clk_sel <= 1'b0;
            source_sel <= cwg_pkg::RESET_SOURCE;
            steer_sel <= cwg_pkg::RESET_STEER;
            rise_buf <= cwg_pkg::RESET_DB;
            fall_buf <= cwg_pkg::RESET_DB;
        end else if (reg_write_in) begin
            unique case (reg_addr_in)
                cwg_pkg::ADDR_POLARITY: output_polarity_bits <= reg_wdata_in[3:0];
                cwg_pkg::ADDR_CLOCK_CONTROL: clk_sel <= reg_wdata_in[cwg_pkg::CLK_SEL_BIT];
                cwg_pkg::ADDR_INPUT_SELECT: source_sel <= reg_wdata_in[3:0];
                cwg_pkg::ADDR_STEERING: steer_sel <= reg_wdata_in[3:0];
                cwg_pkg::ADDR_RISING_DB: rise_buf <= reg_wdata_in[cwg_pkg::DB_W-1:0];
                cwg_pkg::ADDR_FALLING_DB: fall_buf <= reg_wdata_in[cwg_pkg::DB_W-1:0];
                default: ;
            endcase
        end
    end

    // active dead-band values: follow buffer when off, else on a falling edge while load_request is set
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rise_act <= cwg_pkg::RESET_DB;
            fall_act <= cwg_pkg::RESET_DB;
        end else if (!enable || (load_request && data_fall)) begin
            rise_act <= rise_buf;
            fall_act <= fall_buf;
        end
    end

    // input edge detector
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            data_q <= 1'b0;
        end else begin
            data_q <= input_waveform;
        end
    end

    // two independent dead-band counters, restarted by the opposite level
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rise_cnt <= '0;
            fall_cnt <= '0;
        end else begin
            // edges are sampled on the core clock, so delay jitters by one tick
            rise_cnt <= input_waveform ? db_step(rise_cnt, rise_act, gen_tick) : '0;
            fall_cnt <= input_waveform ? '0 : db_step(fall_cnt, fall_act, gen_tick);
        end
    end

    // full-bridge direction taken at a rising input edge
    always_comb begin
        next_reverse = reverse;
        if (data_rise) begin
            next_reverse = mode[0];
        end
    end

    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            reverse <= 1'b0;
            fb_hold <= 1'b0;
            fb_cnt <= '0;
        end else if (!enable || !is_full_bridge) begin
            // a mode written now sets the entry direction, not the mode it replaces
            reverse <= wr_ctrl ? reg_wdata_in[cwg_pkg::MODE_LSB] : mode[0];
            fb_hold <= 1'b0;
            fb_cnt <= '0;
        end else if (next_reverse != reverse) begin
            reverse <= next_reverse;
            fb_hold <= 1'b1;
            // count starts at the edge itself, as in half-bridge
            fb_cnt <= db_step('0, next_reverse ? rise_act : fall_act, gen_tick);
        end else if (fb_hold) begin
            fb_cnt <= db_step(fb_cnt, reverse ? rise_act : fall_act, gen_tick);
            if (fb_cnt == (reverse ? rise_act : fall_act)) begin
                fb_hold <= 1'b0;
            end
        end
    end

    // push-pull sequencer
    always_comb begin
        next_route_b = route_b;
        if (data_rise) begin
            next_route_b = next_is_b;
        end
    end

    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            next_is_b <= 1'b0;
            route_b <= 1'b0;
        end else if (seq_clear) begin
            next_is_b <= 1'b0;
            route_b <= 1'b0;
        end else begin
            route_b <= next_route_b;
            if (data_rise && mode == cwg_pkg::MODE_PUSH_PULL) begin
                next_is_b <= ~next_is_b;
            end
        end
    end

    // steering selection: sync mode latches at rising edge, async follows at once
    always_comb begin
        next_steer = steer_act;
        if (mode == cwg_pkg::MODE_STEER_ASYNC || data_rise) begin
            next_steer = steer_sel;
        end
    end

    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            steer_act <= cwg_pkg::RESET_STEER;
        end else begin
            steer_act <= next_steer;
        end
    end

    // raw levels before polarity, 1 means active
    always_comb begin
        raw = 4'h0;
        unique case (mode)
            cwg_pkg::MODE_HALF_BRIDGE: begin
                raw[0] = input_waveform && rise_cnt == rise_act;
                raw[1] = !input_waveform && fall_cnt == fall_act;
                raw[2] = raw[0];
                raw[3] = raw[1];
            end
            cwg_pkg::MODE_PUSH_PULL: begin
                raw[0] = input_waveform && !next_route_b;
                raw[1] = input_waveform && next_route_b;
                raw[2] = raw[0];
                raw[3] = raw[1];
            end
            cwg_pkg::MODE_FB_FORWARD, cwg_pkg::MODE_FB_REVERSE: begin
                if (next_reverse) begin
                    raw[2] = 1'b1;
                    raw[1] = input_waveform && fb_open && next_reverse == reverse;
                end else begin
                    raw[0] = 1'b1;
                    raw[3] = input_waveform && fb_open && next_reverse == reverse;
                end
            end
            cwg_pkg::MODE_STEER_ASYNC, cwg_pkg::MODE_STEER_SYNC: begin
                // unsteered pins held low before polarity; polarity never gates steering
                raw = next_steer & {4{input_waveform}};
            end
            default: raw = 4'h0;
        endcase
        if (!enable) begin
            raw = 4'h0;
        end
    end

    // registered pin drivers
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            wave_out_a <= 1'b0;
            wave_out_b <= 1'b0;
            wave_out_c <= 1'b0;
            wave_out_d <= 1'b0;
        end else begin
            wave_out_a <= apply_pol(raw[0], output_polarity_bits[0]);
            wave_out_b <= apply_pol(raw[1], output_polarity_bits[1]);
            wave_out_c <= apply_pol(raw[2], output_polarity_bits[2]);
            wave_out_d <= apply_pol(raw[3], output_polarity_bits[3]);
        end
    end

    // read port, data one cycle after the strobe, zero when idle or unmapped
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            reg_rdata_out <= 8'h00;
        end else if (!reg_read_in) begin
            reg_rdata_out <= 8'h00;
        end else begin
            unique case (reg_addr_in)
                cwg_pkg::ADDR_CONTROL_0: reg_rdata_out <= {enable, load_request, 3'h0, mode};
                cwg_pkg::ADDR_POLARITY: reg_rdata_out <= {4'h0, output_polarity_bits};
                cwg_pkg::ADDR_CLOCK_CONTROL: reg_rdata_out <= {7'h00, clk_sel};
                cwg_pkg::ADDR_INPUT_SELECT: reg_rdata_out <= {4'h0, source_sel};
                cwg_pkg::ADDR_RISING_DB: reg_rdata_out <= {2'h0, rise_buf};
                cwg_pkg::ADDR_FALLING_DB: reg_rdata_out <= {2'h0, fall_buf};
                cwg_pkg::ADDR_STEERING: reg_rdata_out <= {4'h0, steer_sel};
                cwg_pkg::ADDR_STATUS: reg_rdata_out <= {shutdown_in, next_is_b, fb_hold,
                    reverse, wave_out_d, wave_out_c, wave_out_b, wave_out_a};
                default: reg_rdata_out <= 8'h00;
            endcase
        end
    end

endmodule // cwg_top
`default_nettype wire

// ---- tb/cwg_checker.sv ----
// port assertions for the complementary waveform generator
`timescale 1ns/1ns
`default_nettype none
module cwg_checker #(
    parameter int SRC_COUNT = 16
) (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic reset_n_in,
    // register port
    input wire logic [cwg_pkg::ADDR_W-1:0] reg_addr_in,
    input wire logic [cwg_pkg::DATA_W-1:0] reg_wdata_in,
    input wire logic reg_write_in,
    input wire logic reg_read_in,
    input wire logic [cwg_pkg::DATA_W-1:0] reg_rdata_out,
    // sources and events
    input wire logic [SRC_COUNT-1:0] input_sources_in,
    input wire logic fast_osc_tick_in,
    input wire logic shutdown_in,
    // pins
    input wire logic wave_out_a,
    input wire logic wave_out_b,
    input wire logic wave_out_c,
    input wire logic wave_out_d
);
    logic [7:0] ctl;
    logic [3:0] pol;
    logic [3:0] sel;
    logic [3:0] steer;
    // shadow copies so each check knows the mode in force
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ctl <= 8'h00;
            pol <= cwg_pkg::RESET_POLARITY;
            sel <= cwg_pkg::RESET_SOURCE;
            steer <= cwg_pkg::RESET_STEER;
        end else if (reg_write_in) begin
            case (reg_addr_in)
                cwg_pkg::ADDR_CONTROL_0: ctl <= reg_wdata_in;
                cwg_pkg::ADDR_POLARITY: pol <= reg_wdata_in[3:0];
                cwg_pkg::ADDR_INPUT_SELECT: sel <= reg_wdata_in[3:0];
                cwg_pkg::ADDR_STEERING: steer <= reg_wdata_in[3:0];
                default: ;
            endcase
        end
    end
    wire logic in_w = input_sources_in[sel];
    wire logic [3:0] pins = {wave_out_d, wave_out_c, wave_out_b, wave_out_a};
    wire logic en = ctl[cwg_pkg::EN_BIT];
    wire logic [2:0] md = ctl[2:0];
    wire logic hb = en && md == cwg_pkg::MODE_HALF_BRIDGE;
    wire logic pp = en && md == cwg_pkg::MODE_PUSH_PULL;
    wire logic fb = en && md[2:1] == 2'b01;
    wire logic sa = en && md == cwg_pkg::MODE_STEER_ASYNC;
    wire logic ss = en && md == cwg_pkg::MODE_STEER_SYNC;
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!reset_n_in);
    a_disabled_inactive: assert property (!$past(en) |-> pins == ~$past(pol))
        else $error("outputs not inactive while disabled");
    a_hb_a_low: assert property ($past(hb) && !$past(in_w) |-> wave_out_a == !$past(pol[0]))
        else $error("half bridge A active with input low");
    a_hb_b_low: assert property ($past(hb) && $past(in_w) |-> wave_out_b == !$past(pol[1]))
        else $error("half bridge B active with input high");
    a_mirror_cd: assert property ($past(hb || pp) |->
        (wave_out_c ~^ $past(pol[2])) == (wave_out_a ~^ $past(pol[0])) &&
        (wave_out_d ~^ $past(pol[3])) == (wave_out_b ~^ $past(pol[1])))
        else $error("C or D does not follow A or B");
    a_pp_exclusive: assert property ($past(pp) |->
        !(wave_out_a == $past(pol[0]) && wave_out_b == $past(pol[1])))
        else $error("push-pull A and B active together");
    a_fb_low: assert property ($past(fb) && !$past(in_w) |->
        wave_out_b == !$past(pol[1]) && wave_out_d == !$past(pol[3]))
        else $error("full bridge modulated pin active with input low");
    a_async_steer: assert property ($past(sa) |->
        pins == (~$past(pol) ^ ($past(steer) & {4{$past(in_w)}})))
        else $error("async steering output wrong");
    a_sync_low: assert property ($past(ss) && !$past(in_w) |-> pins == ~$past(pol))
        else $error("sync steering pin active with input low");
    a_read_pol: assert property ($past(reg_read_in && reg_addr_in == cwg_pkg::ADDR_POLARITY)
        |-> reg_rdata_out[3:0] == $past(pol))
        else $error("polarity readback wrong");
    a_read_idle: assert property (!$past(reg_read_in) |-> reg_rdata_out == 8'h00)
        else $error("read data outside its cycle");
endmodule // cwg_checker
bind cwg_top cwg_checker #(.SRC_COUNT(SRC_COUNT)) u_chk (.core_clk_in(core_clk_in),
    .reset_n_in(reset_n_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_write_in(reg_write_in), .reg_read_in(reg_read_in), .reg_rdata_out(reg_rdata_out),
    .input_sources_in(input_sources_in), .fast_osc_tick_in(fast_osc_tick_in),
    .shutdown_in(shutdown_in), .wave_out_a(wave_out_a), .wave_out_b(wave_out_b),
    .wave_out_c(wave_out_c), .wave_out_d(wave_out_d));
`default_nettype wire

// ---- tb/cwg_wave_src.sv ----
// input waveform source model with a busy set of unused sources
`timescale 1ns/1ns
`default_nettype none
module cwg_wave_src #(
    parameter int SRC_COUNT = 16,
    parameter int SRC_SEL = 5
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // shape, a zero length holds the other level
    input wire logic [7:0] high_len_in,
    input wire logic [7:0] low_len_in,
    // candidate waveforms
    output logic [SRC_COUNT-1:0] sources_out
);
    logic [7:0] cnt;
    logic lvl;
    logic [SRC_COUNT-1:0] noise;
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt <= 8'h00;
            lvl <= 1'b0;
            noise <= '0;
        end else begin
            // unused sources count up as one binary counter each cycle so a wrong select shows
            noise <= noise + 1'b1;
            cnt <= cnt + 8'h01;
            if (lvl && low_len_in != 8'h00 && cnt + 8'h01 >= high_len_in ||
                !lvl && high_len_in != 8'h00 && cnt + 8'h01 >= low_len_in) begin
                lvl <= !lvl;
                cnt <= 8'h00;
            end
        end
    end
    always_comb begin
        sources_out = noise;
        sources_out[SRC_SEL] = lvl;
    end
endmodule // cwg_wave_src
`default_nettype wire

// ---- tb/test_complementary_waveform_generator.sv ----
// self-checking bench for the complementary waveform generator
`timescale 1ns/1ns
`default_nettype none
module test_complementary_waveform_generator;
    logic core_clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic [3:0] reg_addr_in = 4'h0;
    logic [7:0] reg_wdata_in = 8'h00;
    logic reg_write_in = 1'b0;
    logic reg_read_in = 1'b0;
    logic [7:0] reg_rdata_out;
    logic [15:0] input_sources_in;
    logic fast_osc_tick_in = 1'b0;
    logic shutdown_in = 1'b0;
    logic wave_out_a, wave_out_b, wave_out_c, wave_out_d;
    logic [7:0] hi_len = 8'h0A;
    logic [7:0] lo_len = 8'h0A;
    logic tick_run = 1'b0;
    logic [7:0] rd_val;
    int n_mismatch = 0;
    int n_checks = 0;
    int cycles = 0;
    int n;
    wire logic [3:0] pins = {wave_out_d, wave_out_c, wave_out_b, wave_out_a};
    wire logic in_w = input_sources_in[5];
    always #50 core_clk_in = ~core_clk_in;
    // fast tick every other cycle
    always @(posedge core_clk_in) fast_osc_tick_in <= tick_run && !fast_osc_tick_in;
    always @(posedge core_clk_in) begin
        cycles = cycles + 1;
        if (cycles == 5000) begin
            n_mismatch = n_mismatch + 1;
            wrap_up();
        end
    end
    cwg_top dut (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in), .reg_read_in(reg_read_in),
        .reg_rdata_out(reg_rdata_out), .input_sources_in(input_sources_in),
        .fast_osc_tick_in(fast_osc_tick_in), .shutdown_in(shutdown_in), .wave_out_a(wave_out_a),
        .wave_out_b(wave_out_b), .wave_out_c(wave_out_c), .wave_out_d(wave_out_d));
    cwg_wave_src src (.clk_in(core_clk_in), .rst_n_in(reset_n_in), .high_len_in(hi_len),
        .low_len_in(lo_len), .sources_out(input_sources_in));
    task automatic wrap_up();
        if (n_mismatch == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks = n_checks + 1;
        if (seen !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_write_in <= 1'b1;
        @(posedge core_clk_in);
        reg_write_in <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge core_clk_in);
        reg_addr_in <= a;
        reg_read_in <= 1'b1;
        @(posedge core_clk_in);
        reg_read_in <= 1'b0;
        @(negedge core_clk_in);
        rd_val = reg_rdata_out;
    endtask
    // returns at the first low phase that shows the input newly changed to lvl
    task automatic edge_wait(input logic lvl);
        logic prv;
        prv = in_w;
        for (int i = 0; i < 60; i++) begin
            @(negedge core_clk_in);
            if (in_w === lvl && prv === !lvl) break;
            prv = in_w;
        end
    endtask
    // cycles from an input edge to the rise of one pin, 99 if none
    task automatic delay(input logic lvl, input int pin, output int cnt);
        cnt = 99;
        edge_wait(lvl);
        for (int i = 0; i < 40 && cnt == 99; i++) begin
            if (pins[pin] === 1'b1) cnt = i;
            @(negedge core_clk_in);
        end
    endtask
    task automatic pp(input logic [3:0] exp);
        edge_wait(1'b1);
        repeat (3) @(negedge core_clk_in);
        chk(pins, exp);
    endtask
    initial begin
        repeat (4) @(posedge core_clk_in);
        reset_n_in <= 1'b1;
        rd(cwg_pkg::ADDR_POLARITY);
        chk(rd_val, 8'h0F);
        wr(4'h9, 8'hFF);
        rd(4'h9);
        chk(rd_val, 8'h00);
        wr(cwg_pkg::ADDR_POLARITY, 8'h05);
        repeat (2) @(negedge core_clk_in);
        chk(pins, 8'h0A);
        wr(cwg_pkg::ADDR_POLARITY, 8'h0F);
        wr(cwg_pkg::ADDR_INPUT_SELECT, 8'h05);
        wr(cwg_pkg::ADDR_RISING_DB, 8'h03);
        wr(cwg_pkg::ADDR_FALLING_DB, 8'h01);
        wr(cwg_pkg::ADDR_CONTROL_0, 8'h84);
        delay(1'b1, 0, n);
        chk(8'(n), 8'h04);
        delay(1'b0, 1, n);
        chk(8'(n), 8'h02);
        hi_len <= 8'h02;
        delay(1'b1, 0, n);
        chk(8'(n), 8'h63);
        hi_len <= 8'h0A;
        wr(cwg_pkg::ADDR_RISING_DB, 8'h00);
        delay(1'b1, 0, n);
        chk(8'(n), 8'h04);
        edge_wait(1'b1);
        wr(cwg_pkg::ADDR_CONTROL_0, 8'hC4);
        rd(cwg_pkg::ADDR_CONTROL_0);
        chk(rd_val, 8'hC4);
        edge_wait(1'b0);
        rd(cwg_pkg::ADDR_CONTROL_0);
        chk(rd_val, 8'h84);
        delay(1'b1, 0, n);
        chk(8'(n), 8'h01);
        // disabled writes load at once, so no load request needed
        wr(cwg_pkg::ADDR_CONTROL_0, 8'h04);
        wr(cwg_pkg::ADDR_RISING_DB, 8'h02);
        wr(cwg_pkg::ADDR_CLOCK_CONTROL, 8'h01);
        tick_run <= 1'b1;
        wr(cwg_pkg::ADDR_CONTROL_0, 8'h84);
        delay(1'b1, 0, n);
        chk(8'(n > 3 && n < 8), 8'h01);
        wr(cwg_pkg::ADDR_CLOCK_CONTROL, 8'h00);
        tick_run <= 1'b0;
        hi_len <= 8'h06;
        lo_len <= 8'h06;
        wr(cwg_pkg::ADDR_CONTROL_0, 8'h85);
        pp(4'h5);
        pp(4'hA);
        pp(4'h5);
        @(posedge core_clk_in);
        shutdown_in <= 1'b1;
        @(posedge core_clk_in);
        shutdown_in <= 1'b0;
        pp(4'h5);
        wr(cwg_pkg::ADDR_CONTROL_0, 8'h05);
        wr(cwg_pkg::ADDR_CONTROL_0, 8'h85);
        pp(4'h5);
        hi_len <= 8'h0A;
        lo_len <= 8'h0A;
        wr(cwg_pkg::ADDR_CONTROL_0, 8'h82);
        edge_wait(1'b1);
        edge_wait(1'b1);
        repeat (5) @(negedge core_clk_in);
        chk(pins, 8'h09);
        wr(cwg_pkg::ADDR_CONTROL_0, 8'h83);
        delay(1'b1, 1, n);
        chk(8'(n), 8'h03);
        chk(pins, 8'h06);
        lo_len <= 8'h00;
        wr(cwg_pkg::ADDR_CONTROL_0, 8'h80);
        wr(cwg_pkg::ADDR_STEERING, 8'h05);
        @(negedge core_clk_in);
        chk(pins, 8'h00);
        @(negedge core_clk_in);
        chk(pins, 8'h05);
        wr(cwg_pkg::ADDR_CONTROL_0, 8'h81);
        wr(cwg_pkg::ADDR_STEERING, 8'h0A);
        repeat (3) @(negedge core_clk_in);
        chk(pins, 8'h05);
        lo_len <= 8'h04;
        edge_wait(1'b1);
        repeat (2) @(negedge core_clk_in);
        chk(pins, 8'h0A);
        // unused mode code keeps every pin inactive
        wr(cwg_pkg::ADDR_CONTROL_0, 8'h86);
        repeat (2) @(negedge core_clk_in);
        chk(pins, 8'h00);
        // sequencer kept its B-next state outside push-pull
        rd(cwg_pkg::ADDR_STATUS);
        chk(rd_val, 8'h40);
        wrap_up();
    end
endmodule // test_complementary_waveform_generator
`default_nettype wire
